/* logic/wdc_top.sv */
// Watchdog counter with its prescaler, configuration bits and stop handling.
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps

// Notes on behaviour
// - Six-bit watchdog counter advances on carry of a twelve-bit prescaler.
// - Unserviced watchdog overflows after 8176 or 262128 cycles by rate select.
// - Clear write zeroes watchdog counter and prescaler stages twelve to five.
// - Every clear write starts a new timeout, whatever data was written.
// - Reading the clear location returns the reset vector low byte.
// - Overflow drives reset pin low 32 cycles if enabled, sets cause flag.
// - Executing the stop instruction zeroes the prescaler.
// - Power-up sequencing zeroes the prescaler 4096 cycles after power up.
// - Any internal reset zeroes prescaler and watchdog counter.
// - Monitor mode with high test voltage on interrupt pin inhibits watchdog.
// - Watchdog keeps counting during wait mode.
// - Stop mode gates the watchdog clock and zeroes the prescaler.
// - Break in monitor mode inhibits watchdog when break disable bit set.
// - Watchdog never raises an interrupt; overflow only resets.
// - Watchdog disable bit stops the watchdog when one.
// - Stop enable zero makes stop an illegal opcode; one executes stop.
// - Short recovery bit picks 32-cycle stop exit, otherwise 4096 cycles.
// - Stop exit caused by low-voltage reset always uses long recovery.
// - In stop, rate select picks wakeup period 512 or 16384 clocks.
// - Low-voltage stop enable keeps inhibit alive in stop unless powered down.
// - Reset disable blocks low-voltage resets; power disable powers it down.
// - Trip select picks 5-V or 3-V; only power-on reset clears it.
// - Configuration register takes one write per reset, readable always.
// - Outside stop, rate select one gives short period, zero the long one.
module wdc_top
    import wdc_pkg::*;
#(
    parameter int unsigned WD_SHORT_CYCLES = WD_SHORT_CYC,
    parameter int unsigned WD_LONG_CYCLES  = WD_LONG_CYC
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        sys_reset_i,
    input  wire logic [31:0] paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [7:0]  reset_vector_low_i,
    input  wire logic        reset_pin_enable_i,
    input  wire logic        monitor_mode_i,
    input  wire logic        high_test_voltage_i,
    input  wire logic        break_active_i,
    input  wire logic        stop_req_i,
    input  wire logic        wake_req_i,
    input  wire logic        lowv_trip_i,
    output logic             chip_reset_o,
    output logic             reset_pin_o,
    output logic             reset_pin_oe_o,
    output logic             stop_mode_o,
    output logic             illegal_opcode_o,
    output logic             lowv_reset_o,
    output logic             lowv_power_on_o,
    output logic             lowv_trip_select_o,
    output logic [14:0]      awu_period_o
);

    // -------------------------------------------------------------------------
    // State and address decode.
    // -------------------------------------------------------------------------
    wdc_state_t s_ff;
    wdc_state_t nxt_s;

    // Byte address of a register index is four times the index.
    function automatic logic addr_hit(input logic [31:0] addr, input logic [15:0] idx);
        addr_hit = (addr == {14'h0000, idx, 2'b00});
    endfunction

    logic        acc;
    logic        wr;
    logic        hit_clr;
    logic        hit_cfg;
    logic        hit_sts;
    logic        hit_brk;
    logic        int_rst;
    logic        wd_run;
    logic        ovf;
    logic [17:0] ovf_at;
    logic        lv_event;
    logic        lv_active;

    // -------------------------------------------------------------------------
    // Next state.
    // -------------------------------------------------------------------------
    always_comb begin
        nxt_s     = s_ff;
        // The access phase ends at the edge where our registered pready is high.
        acc       = psel_i & penable_i & s_ff.pready;
        wr        = acc & pwrite_i;
        hit_clr   = addr_hit(paddr_i, IDX_WD_CLEAR);
        hit_cfg   = addr_hit(paddr_i, IDX_SYS_CFG_ONE);
        hit_sts   = addr_hit(paddr_i, IDX_WD_STATUS);
        hit_brk   = addr_hit(paddr_i, IDX_BRK_AUX);
        int_rst   = sys_reset_i | s_ff.rst_active;
        // Wait mode has no input here on purpose: the watchdog runs through it.
        wd_run    = ~s_ff.cfg1[CFG_WD_DISABLE]
                  & ~(monitor_mode_i & s_ff.hv)
                  & ~(monitor_mode_i & break_active_i & s_ff.brk_wd_dis)
                  & ~s_ff.stop & ~s_ff.recovering;
        ovf_at    = s_ff.cfg1[CFG_RATE_SEL] ? 18'(WD_SHORT_CYCLES - 1)
                                            : 18'(WD_LONG_CYCLES - 1);
        ovf       = wd_run & ({s_ff.wd, s_ff.presc} == ovf_at);
        // The detector sleeps in stop unless its stop enable bit keeps it awake.
        lv_active = ~s_ff.cfg1[CFG_LV_PWR_DIS]
                  & (~s_ff.stop | s_ff.cfg1[CFG_LV_STOP_EN]);
        lv_event  = lv_active & s_ff.lt & ~s_ff.cfg1[CFG_LV_RST_DIS];

        // Three-stage input filters; a new level counts once stages two and three agree.
        // A pin glitch of one cycle never reaches the filtered level.
        nxt_s.hv_s = {s_ff.hv_s[1:0], high_test_voltage_i};
        if (s_ff.hv_s[1] == s_ff.hv_s[2]) begin
            nxt_s.hv = s_ff.hv_s[2];
        end
        nxt_s.lt_s = {s_ff.lt_s[1:0], lowv_trip_i};
        if (s_ff.lt_s[1] == s_ff.lt_s[2]) begin
            nxt_s.lt = s_ff.lt_s[2];
        end
        nxt_s.lowv_reset    = lv_event;
        nxt_s.lowv_power_on = lv_active;

        // Prescaler feeds the watchdog counter through its carry.
        // Its low four bits survive a clear, so a fresh period may run up to
        // fifteen cycles short; software must service with that margin.
        if (wd_run) begin
            nxt_s.presc = s_ff.presc + 12'h001;
            if (s_ff.presc == 12'hfff) begin
                nxt_s.wd = s_ff.wd + 6'h01;
            end
        end

        // Power-up sequencing zeroes the prescaler once, after the delay.
        // Internal resets leave the sequencer finished.
        if (!s_ff.por_done) begin
            nxt_s.por_cnt = s_ff.por_cnt + 13'h0001;
            if (s_ff.por_cnt == 13'(POR_DELAY_CYC - 1)) begin
                nxt_s.por_done = 1'b1;
                nxt_s.presc    = 12'h000;
            end
        end

        // Overflow starts the reset pulse; the flag set wins over a software clear.
        // A clear write in the overflow cycle itself comes too late to stop
        // the pulse; only a clear before that cycle counts.
        if (wr && hit_sts && pwdata_i[STS_WD_CAUSE]) begin
            nxt_s.wd_cause = 1'b0;
        end
        if (ovf && !s_ff.rst_active) begin
            nxt_s.rst_active = 1'b1;
            nxt_s.rst_cnt    = 6'(RST_PULSE_CYC - 1);
            nxt_s.pin_drive  = reset_pin_enable_i;
            nxt_s.wd_cause   = 1'b1;
        end else if (s_ff.rst_active) begin
            nxt_s.rst_cnt = s_ff.rst_cnt - 6'h01;
            if (s_ff.rst_cnt == 6'h00) begin
                nxt_s.rst_active = 1'b0;
                nxt_s.pin_drive  = 1'b0;
            end
        end

        // Clear writes only strobe the counters; nothing is stored.
        if (wr && hit_clr) begin
            nxt_s.wd          = 6'h00;
            nxt_s.presc[11:4] = 8'h00;
        end

        // Stop request: refused as illegal unless enabled, else stop is entered.
        // Stop leaves the watchdog counter itself alone, so software should
        // service it just before stopping to get a full period after wakeup.
        nxt_s.illegal = 1'b0;
        if (stop_req_i && !s_ff.stop && !s_ff.recovering) begin
            if (s_ff.cfg1[CFG_STOP_EN]) begin
                nxt_s.stop  = 1'b1;
                nxt_s.presc = 12'h000;
            end else begin
                nxt_s.illegal = 1'b1;
            end
        end
        if (s_ff.stop) begin
            nxt_s.presc = 12'h000;
            if (wake_req_i || lv_event) begin
                nxt_s.stop       = 1'b0;
                nxt_s.recovering = 1'b1;
                // A low-voltage exit ignores the short recovery choice.
                if (s_ff.cfg1[CFG_SHORT_REC] && !lv_event) begin
                    nxt_s.rec_cnt = 13'(REC_SHORT_CYC - 1);
                end else begin
                    nxt_s.rec_cnt = 13'(REC_LONG_CYC - 1);
                end
            end
        end
        if (s_ff.recovering) begin
            nxt_s.rec_cnt = s_ff.rec_cnt - 13'h0001;
            if (s_ff.rec_cnt == 13'h0000) begin
                nxt_s.recovering = 1'b0;
            end
        end
        nxt_s.awu_period = s_ff.cfg1[CFG_RATE_SEL] ? 15'(AWU_SHORT_CYC)
                                                   : 15'(AWU_LONG_CYC);

        // Configuration takes one write per reset; later writes are dropped quietly.
        if (wr && hit_cfg && !s_ff.cfg_lock) begin
            nxt_s.cfg1     = pwdata_i[7:0];
            nxt_s.cfg_lock = 1'b1;
        end
        if (wr && hit_brk) begin
            nxt_s.brk_wd_dis = pwdata_i[BRK_WD_DISABLE];
        end

        // Bus answer: one wait state, registered data and error.
        // The wait state gives the decode and read mux a whole cycle.
        // Every access thus costs the same, whatever register it reaches.
        nxt_s.pready  = psel_i & penable_i & ~s_ff.pready;
        nxt_s.pslverr = 1'b0;
        nxt_s.prdata  = 32'h0000_0000;
        if (psel_i && penable_i && !s_ff.pready) begin
            if (hit_clr) begin
                nxt_s.prdata = {24'h00_0000, reset_vector_low_i};
            end else if (hit_cfg) begin
                nxt_s.prdata = {24'h00_0000, s_ff.cfg1};
            end else if (hit_sts) begin
                nxt_s.prdata[STS_WD_CAUSE]               = s_ff.wd_cause;
                nxt_s.prdata[STS_STOP_STATE]             = s_ff.stop;
                nxt_s.prdata[STS_CNT_LSB+5:STS_CNT_LSB]  = s_ff.wd;
            end else if (hit_brk) begin
                nxt_s.prdata[BRK_WD_DISABLE] = s_ff.brk_wd_dis;
            end else begin
                nxt_s.pslverr = 1'b1;
            end
        end

        // Internal resets clear counters and reopen configuration; trip select stays.
        // The watchdog pulse is itself an internal reset, so from its second cycle on the counters
        // are held at zero and configuration at its reset value; writes during it do not stick.
        if (int_rst) begin
            nxt_s.presc      = 12'h000;
            nxt_s.wd         = 6'h00;
            nxt_s.cfg_lock   = 1'b0;
            nxt_s.cfg1       = CFG_ONE_RESET;
            nxt_s.cfg1[CFG_LV_TRIP_SEL] = s_ff.cfg1[CFG_LV_TRIP_SEL];
            nxt_s.brk_wd_dis = 1'b0;
            nxt_s.stop       = 1'b0;
            nxt_s.recovering = 1'b0;
            nxt_s.illegal    = 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // State register; rst_n_i is the power-on reset and clears everything.
    // -------------------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            s_ff      <= '0;
            s_ff.cfg1 <= CFG_ONE_RESET;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // -------------------------------------------------------------------------
    // Outputs, all but the constant reset_pin_o straight from the state register.
    // -------------------------------------------------------------------------
    assign prdata_o           = s_ff.prdata;
    assign pready_o           = s_ff.pready;
    assign pslverr_o          = s_ff.pslverr;
    assign chip_reset_o       = s_ff.rst_active;
    assign reset_pin_o        = 1'b0;     // Open drain: only ever pulls low.
    assign reset_pin_oe_o     = s_ff.pin_drive;
    assign stop_mode_o        = s_ff.stop;
    assign illegal_opcode_o   = s_ff.illegal;
    assign lowv_reset_o       = s_ff.lowv_reset;
    assign lowv_power_on_o    = s_ff.lowv_power_on;
    assign lowv_trip_select_o = s_ff.cfg1[CFG_LV_TRIP_SEL];
    assign awu_period_o       = s_ff.awu_period;

    // -------------------------------------------------------------------------
    // Checks.
    // -------------------------------------------------------------------------
    // All checks run on the system clock and sleep through power-on reset.
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence seq_pulse32;
        s_ff.rst_active ##31 s_ff.rst_active ##1 !s_ff.rst_active;
    endsequence

    sequence seq_short_rec;
        s_ff.recovering ##31 s_ff.recovering ##1 !s_ff.recovering;
    endsequence

    chk_clear_zeroes: assert property (
        (wr && hit_clr && !int_rst && !s_ff.stop) |=> (s_ff.wd == 6'h00)
            && (s_ff.presc[11:4] == 8'h00))
        else $error("clear write did not zero the counters");

    chk_reset_pulse: assert property (
        $rose(s_ff.rst_active) |-> seq_pulse32 ##0 1'b1)
        else $error("watchdog reset pulse is not 32 cycles");

    chk_cause_set: assert property (
        $rose(chip_reset_o) |-> s_ff.wd_cause && (reset_pin_oe_o == $past(reset_pin_enable_i)))
        else $error("cause flag or pin drive wrong on watchdog reset");

    chk_ovf_start: assert property (
        (ovf && !s_ff.rst_active && !(wr && hit_clr)) |=> chip_reset_o)
        else $error("overflow did not start reset");

    chk_clear_read: assert property (
        (psel_i && penable_i && !s_ff.pready && hit_clr) |=>
            (prdata_o == {24'h00_0000, $past(reset_vector_low_i)}) && !pslverr_o)
        else $error("clear location read returned wrong data");

    chk_stop_illegal: assert property (
        (stop_req_i && !s_ff.stop && !s_ff.recovering && !s_ff.cfg1[CFG_STOP_EN] && !int_rst)
            |=> illegal_opcode_o && !stop_mode_o)
        else $error("disabled stop was not refused");

    chk_stop_presc: assert property (
        s_ff.stop |=> (s_ff.presc == 12'h000) || $past(int_rst))
        else $error("prescaler runs in stop");

    chk_cfg_once: assert property (
        (s_ff.cfg_lock && !int_rst) |=> $stable(s_ff.cfg1))
        else $error("locked configuration changed");

    chk_disable_hold: assert property (
        (s_ff.cfg1[CFG_WD_DISABLE] && !int_rst && !(wr && hit_clr)) |=> $stable(s_ff.wd))
        else $error("disabled watchdog counted");

    chk_short_recovery: assert property (
        (s_ff.stop && wake_req_i && !lv_event && s_ff.cfg1[CFG_SHORT_REC] && !int_rst)
            |=> seq_short_rec)
        else $error("short recovery is not 32 cycles");

    chk_lowv_gate: assert property (
        lowv_reset_o |-> !$past(s_ff.cfg1[CFG_LV_RST_DIS]) && !$past(s_ff.cfg1[CFG_LV_PWR_DIS]))
        else $error("low-voltage reset escaped its disable bits");

    // Prescaler clears on stop and power-up, the test-voltage inhibit, trip retention and low-voltage long recovery.
    chk_stop_entry: assert property (
        (stop_req_i && !s_ff.stop && !s_ff.recovering && s_ff.cfg1[CFG_STOP_EN] && !int_rst)
            |=> stop_mode_o && (s_ff.presc == 12'h000))
        else $error("stop entry left the prescaler running");

    chk_por_clear: assert property (
        (!s_ff.por_done && (s_ff.por_cnt == 13'(POR_DELAY_CYC - 1)))
            |=> s_ff.por_done && (s_ff.presc == 12'h000))
        else $error("power-up sequencing did not clear the prescaler");

    chk_monitor_hold: assert property (
        (monitor_mode_i && s_ff.hv && !(wr && hit_clr))
            |=> $stable(s_ff.presc) || (s_ff.presc == 12'h000))
        else $error("watchdog counted under the test voltage");

    chk_trip_keep: assert property (
        sys_reset_i |=> $stable(lowv_trip_select_o))
        else $error("trip select lost on an internal reset");

    chk_lowv_long_rec: assert property (
        (s_ff.stop && lv_event && !int_rst) |=> (s_ff.rec_cnt == 13'(REC_LONG_CYC - 1)))
        else $error("low-voltage stop exit took the short recovery");

endmodule

/* logic/wdc_pkg.sv */
// Register map, field layout, reset values and cycle counts of the watchdog block.
package wdc_pkg;

    // -------------------------------------------------------------------------
    // Register indices; the byte address on the bus is four times the index.
    // -------------------------------------------------------------------------
    localparam logic [15:0] IDX_SYS_CFG_ONE  = 16'h001f;
    localparam logic [15:0] IDX_WD_STATUS    = 16'h0020;
    localparam logic [15:0] IDX_BRK_AUX      = 16'h0021;
    localparam logic [15:0] IDX_WD_CLEAR     = 16'hffff;

    // -------------------------------------------------------------------------
    // Field positions of system_config_one.
    // -------------------------------------------------------------------------
    localparam int CFG_RATE_SEL    = 7;
    localparam int CFG_LV_STOP_EN  = 6;
    localparam int CFG_LV_RST_DIS  = 5;
    localparam int CFG_LV_PWR_DIS  = 4;
    localparam int CFG_LV_TRIP_SEL = 3;
    localparam int CFG_SHORT_REC   = 2;
    localparam int CFG_STOP_EN     = 1;
    localparam int CFG_WD_DISABLE  = 0;

    // -------------------------------------------------------------------------
    // Field positions of the status and break auxiliary registers.
    // -------------------------------------------------------------------------
    localparam int STS_WD_CAUSE    = 0;
    localparam int STS_STOP_STATE  = 1;
    localparam int STS_CNT_LSB     = 8;
    localparam int BRK_WD_DISABLE  = 0;

    // -------------------------------------------------------------------------
    // Reset values.
    // -------------------------------------------------------------------------
    localparam logic [7:0] CFG_ONE_RESET = 8'h00;

    // -------------------------------------------------------------------------
    // Cycle counts in quad bus clock cycles.
    // -------------------------------------------------------------------------
    localparam int WD_SHORT_CYC   = 8176;
    localparam int WD_LONG_CYC    = 262128;
    localparam int RST_PULSE_CYC  = 32;
    localparam int POR_DELAY_CYC  = 4096;
    localparam int REC_SHORT_CYC  = 32;
    localparam int REC_LONG_CYC   = 4096;
    localparam int AWU_SHORT_CYC  = 512;
    localparam int AWU_LONG_CYC   = 16384;

    // -------------------------------------------------------------------------
    // Whole state of the block.
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic [11:0] presc;
        logic [5:0]  wd;
        logic [7:0]  cfg1;
        logic        cfg_lock;
        logic        wd_cause;
        logic        brk_wd_dis;
        logic [12:0] por_cnt;
        logic        por_done;
        logic [5:0]  rst_cnt;
        logic        rst_active;
        logic        pin_drive;
        logic        stop;
        logic        recovering;
        logic [12:0] rec_cnt;
        logic [2:0]  hv_s;
        logic        hv;
        logic [2:0]  lt_s;
        logic        lt;
        logic        lowv_reset;
        logic        lowv_power_on;
        logic        illegal;
        logic [14:0] awu_period;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } wdc_state_t;

endpackage

/* testbench/tb_wdc_top.sv */
// Self-checking testbench of the watchdog block with random and corner stimulus.
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_wdc_top;
    import wdc_pkg::*;
    // -------------------------------------------------------------------------
    // Shortened periods keep the run brief; the overflow windows derive from them, the quiet waits are fixed.
    // -------------------------------------------------------------------------
    localparam int          SHORT_P = 64;
    localparam int          LONG_P  = 256;
    localparam logic [31:0] A_CFG   = {14'h0, IDX_SYS_CFG_ONE, 2'b00};
    localparam logic [31:0] A_STS   = {14'h0, IDX_WD_STATUS, 2'b00};
    localparam logic [31:0] A_BRK   = {14'h0, IDX_BRK_AUX, 2'b00};
    localparam logic [31:0] A_CLR   = {14'h0, IDX_WD_CLEAR, 2'b00};
    localparam logic [31:0] A_BAD   = 32'h0000_0100;
    logic        clk_sys_i, rst_n_i, sys_reset_i, psel_i, penable_i, pwrite_i;
    logic [31:0] paddr_i, pwdata_i, prdata_o, rd;
    logic        pready_o, pslverr_o, err, reset_pin_enable_i, monitor_mode_i;
    logic [7:0]  reset_vector_low_i, v;
    logic        high_test_voltage_i, break_active_i, stop_req_i, wake_req_i, lowv_trip_i;
    logic        chip_reset_o, reset_pin_o, reset_pin_oe_o, stop_mode_o, illegal_opcode_o;
    logic        lowv_reset_o, lowv_power_on_o, lowv_trip_select_o;
    logic [14:0] awu_period_o;
    int          mismatches, checks_done, cycles;
    // -------------------------------------------------------------------------
    // Clock, device and hang guard.
    // -------------------------------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    wdc_top #(.WD_SHORT_CYCLES(SHORT_P), .WD_LONG_CYCLES(LONG_P)) dut_u (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sys_reset_i(sys_reset_i),
        .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .reset_vector_low_i(reset_vector_low_i), .reset_pin_enable_i(reset_pin_enable_i),
        .monitor_mode_i(monitor_mode_i), .high_test_voltage_i(high_test_voltage_i),
        .break_active_i(break_active_i), .stop_req_i(stop_req_i), .wake_req_i(wake_req_i),
        .lowv_trip_i(lowv_trip_i), .chip_reset_o(chip_reset_o), .reset_pin_o(reset_pin_o),
        .reset_pin_oe_o(reset_pin_oe_o), .stop_mode_o(stop_mode_o),
        .illegal_opcode_o(illegal_opcode_o), .lowv_reset_o(lowv_reset_o),
        .lowv_power_on_o(lowv_power_on_o), .lowv_trip_select_o(lowv_trip_select_o),
        .awu_period_o(awu_period_o));
    // The ceiling is several times the expected run, so only a real hang trips it.
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    // -------------------------------------------------------------------------
    // Bus and checking tasks.
    // -------------------------------------------------------------------------
    // One APB transfer; the request is held until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        psel_i <= 1'b1; penable_i <= 1'b0; paddr_i <= a; pwrite_i <= w; pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0; penable_i <= 1'b0;
    endtask
    // Watches for any reset pulse over a quiet stretch.
    task automatic wait_quiet(input int n);
        repeat (n) begin
            @(posedge clk_sys_i);
            `CHK(chip_reset_o, 1'b0)
        end
    endtask
    // Times an unserviced period from a clear write, then the pulse width.
    task automatic overflow(input int p);
        int n;
        int len;
        n = 0;
        len = 0;
        apb(1'b1, A_CLR, $urandom);
        while (chip_reset_o !== 1'b1 && n < 2000) begin
            @(posedge clk_sys_i);
            n++;
        end
        `CHK(n >= p - 18 && n <= p + 3, 1'b1)
        `CHK(reset_pin_oe_o, 1'b1)
        `CHK(reset_pin_o, 1'b0)
        while (chip_reset_o === 1'b1 && len < 100) begin
            @(posedge clk_sys_i);
            len++;
        end
        `CHK(len, 32)
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // -------------------------------------------------------------------------
    // Main sequence.
    // -------------------------------------------------------------------------
    initial begin
        mismatches = 0; checks_done = 0; cycles = 0;
        rst_n_i = 1'b0; sys_reset_i = 1'b0; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0;
        paddr_i = '0; pwdata_i = '0; reset_pin_enable_i = 1'b1; monitor_mode_i = 1'b0;
        high_test_voltage_i = 1'b0; break_active_i = 1'b0; stop_req_i = 1'b0;
        wake_req_i = 1'b0; lowv_trip_i = 1'b0;
        void'($urandom(32'h29da976e));
        reset_vector_low_i = 8'($urandom);
        repeat (3) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        // Reset value, reset vector readback and an unmapped place.
        apb(1'b0, A_CFG, 32'h0);
        `CHK(rd, {24'h0, CFG_ONE_RESET})
        apb(1'b1, A_CLR, {24'h0, ~reset_vector_low_i});
        apb(1'b0, A_CLR, 32'h0);
        `CHK(rd, {24'h0, reset_vector_low_i})
        apb(1'b0, A_BAD, 32'h0);
        `CHK(err, 1'b1)
        // Stop refused while the enable bit is still clear.
        @(posedge clk_sys_i) stop_req_i <= 1'b1;
        @(posedge clk_sys_i) stop_req_i <= 1'b0;
        @(negedge clk_sys_i) `CHK(illegal_opcode_o, 1'b1)
        // One write per reset; a second write with inverted data is dropped.
        v = {1'b1, 4'($urandom), 3'b110};
        apb(1'b1, A_CFG, {24'h0, v});
        apb(1'b1, A_CFG, {24'h0, ~v});
        apb(1'b0, A_CFG, 32'h0);
        `CHK(rd, {24'h0, v})
        `CHK(lowv_trip_select_o, v[3])
        `CHK(lowv_power_on_o, ~v[4])
        // Repeated clears with random data hold off the short period.
        repeat (6) begin
            apb(1'b1, A_CLR, $urandom);
            wait_quiet(40);
        end
        overflow(SHORT_P);
        apb(1'b0, A_STS, 32'h0);
        `CHK(rd[STS_WD_CAUSE], 1'b1)
        `CHK(rd[13:8], 6'h00)
        apb(1'b1, A_STS, 32'h1);
        apb(1'b0, A_CFG, 32'h0);
        `CHK(rd, {24'h0, v & 8'h08})
        // Long period with rate select clear.
        overflow(LONG_P);
        // Disable bit stops the watchdog entirely.
        apb(1'b1, A_CFG, {24'h0, v & 8'h08 | 8'h01});
        wait_quiet(600);
        @(posedge clk_sys_i) sys_reset_i <= 1'b1;
        @(posedge clk_sys_i) sys_reset_i <= 1'b0;
        // Monitor mode with the test voltage inhibits counting.
        apb(1'b1, A_CFG, {24'h0, v & 8'h08 | 8'h86});
        apb(1'b1, A_CLR, 32'h0);
        monitor_mode_i <= 1'b1; high_test_voltage_i <= 1'b1;
        wait_quiet(300);
        high_test_voltage_i <= 1'b0;
        // Break in monitor mode with the disable bit set inhibits counting too.
        apb(1'b1, A_BRK, 32'h1);
        apb(1'b1, A_CLR, 32'h0);
        break_active_i <= 1'b1;
        wait_quiet(300);
        break_active_i <= 1'b0; monitor_mode_i <= 1'b0;
        // Stop gates the watchdog; the rate bit picks the wakeup period there.
        apb(1'b1, A_CLR, 32'h0);
        @(posedge clk_sys_i) stop_req_i <= 1'b1;
        @(posedge clk_sys_i) stop_req_i <= 1'b0;
        @(negedge clk_sys_i) `CHK(stop_mode_o, 1'b1)
        `CHK(awu_period_o, 15'(AWU_SHORT_CYC))
        wait_quiet(300);
        @(posedge clk_sys_i) wake_req_i <= 1'b1;
        @(posedge clk_sys_i) wake_req_i <= 1'b0;
        @(negedge clk_sys_i) `CHK(stop_mode_o, 1'b0)
        wait_quiet(32);
        apb(1'b1, A_CLR, 32'h0);
        // Trip select survives an internal reset but not power-on reset.
        `CHK(lowv_trip_select_o, v[3])
        @(posedge clk_sys_i) rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(negedge clk_sys_i) `CHK(lowv_trip_select_o, 1'b0)
        // A low-voltage trip in stop wakes the part into the long recovery.
        apb(1'b1, A_CFG, 32'h46);
        @(posedge clk_sys_i) stop_req_i <= 1'b1;
        @(posedge clk_sys_i) stop_req_i <= 1'b0;
        lowv_trip_i <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        @(negedge clk_sys_i) `CHK(stop_mode_o, 1'b0)
        `CHK(lowv_reset_o, 1'b1)
        `CHK(awu_period_o, 15'(AWU_LONG_CYC))
        wait_quiet(4200);
        summarize();
    end
endmodule
